// ===== chan0_regs_pkg.sv
// Package with the register map, field layout, reset values and types of the channel 0 bank.
package chan0_regs_pkg;

    // Register word width and the number of data bits on the bus.
    localparam int unsigned REG_W  = 16;
    localparam int unsigned DATA_W = 32;

    // Register indices; the byte address on the bus is four times the index.
    localparam logic [5:0] IDX_THRESH_LOW = 6'h08;
    localparam logic [5:0] IDX_CFG        = 6'h09;
    localparam logic [5:0] IDX_OCAL_HI    = 6'h0A;
    localparam logic [5:0] IDX_OCAL_LO    = 6'h0B;
    localparam logic [5:0] IDX_GCAL_HI    = 6'h0C;
    localparam logic [5:0] IDX_GCAL_LO    = 6'h0D;

    // Position of the register index inside the byte address.
    localparam int unsigned ADDR_IDX_LSB = 2;
    localparam int unsigned ADDR_IDX_MSB = 7;

    // Field positions of the threshold low register.
    localparam int unsigned THR_BYTE_MSB = 15;
    localparam int unsigned THR_BYTE_LSB = 8;
    localparam int unsigned DCB_SEL_MSB  = 3;
    localparam int unsigned DCB_SEL_LSB  = 0;

    // Field positions of the channel 0 configuration register.
    localparam int unsigned PHASE_MSB  = 15;
    localparam int unsigned PHASE_LSB  = 6;
    localparam int unsigned DCOFF_BIT  = 2;
    localparam int unsigned INSEL_MSB  = 1;
    localparam int unsigned INSEL_LSB  = 0;

    // Field positions of the calibration low registers.
    localparam int unsigned CAL_LO_MSB = 15;
    localparam int unsigned CAL_LO_LSB = 8;

    // Reset values.
    localparam logic [15:0] RST_THRESH_LOW = 16'h0000;
    localparam logic [15:0] RST_CFG        = 16'h0000;
    localparam logic [15:0] RST_OCAL_HI    = 16'h0000;
    localparam logic [15:0] RST_OCAL_LO    = 16'h0000;
    localparam logic [15:0] RST_GCAL_HI    = 16'h8000;
    localparam logic [15:0] RST_GCAL_LO    = 16'h0000;

    // Writable bits of each register; reserved bits stay zero.
    localparam logic [15:0] WMASK_THRESH_LOW = 16'hFF0F;
    localparam logic [15:0] WMASK_CFG        = 16'hFFC7;
    localparam logic [15:0] WMASK_CAL_HI     = 16'hFFFF;
    localparam logic [15:0] WMASK_CAL_LO     = 16'hFF00;

    // AHB transfer types used by the slave.
    localparam logic [1:0] HTRANS_IDLE   = 2'h0;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

    // Input selection codes of channel 0.
    typedef enum logic [1:0] {
        INSEL_PINS     = 2'h0,
        INSEL_SHORTED  = 2'h1,
        INSEL_POS_TEST = 2'h2,
        INSEL_NEG_TEST = 2'h3
    } chan0_input_sel_t;

    // One-hot states of the bus slave.
    typedef enum logic [1:0] {
        BUS_IDLE   = 2'h1,
        BUS_RDWAIT = 2'h2
    } bus_state_t;

    // Channel 0 configuration as seen by the datapath.
    typedef struct packed {
        logic [9:0]       chan0_phase_delay;
        logic             chan0_dc_removal_off;
        chan0_input_sel_t chan0_input_select;
    } chan0_cfg_t;

    // Channel 0 calibration words, 24 bits each.
    typedef struct packed {
        logic [23:0] offset;
        logic [23:0] gain;
    } chan0_cal_t;

endpackage : chan0_regs_pkg

// ===== dc_removal_decode.sv
// DC removal filter coefficient decoder for channel 0, with registered outputs.
`timescale 1ns/1ps
`default_nettype none
module dc_removal_decode (
    input  wire logic       clk,          // Device clock.
    input  wire logic       reset,        // Synchronous reset, active high.
    input  wire logic [3:0] coef_sel,     // Shared coefficient selection code.
    input  wire logic       chan_off,     // Channel disable of the filter.
    output logic            filter_on_q,  // Filter active for this channel.
    output logic [4:0]      shift_q       // Coefficient is two to the minus this.
);
    import chan0_regs_pkg::*;

    // Code zero turns the filter off everywhere; the channel bit overrides per channel.
    always_ff @(posedge clk) begin
        if (reset) begin
            filter_on_q <= 1'b0;
            shift_q     <= 5'h00;
        end else if ((coef_sel == 4'h0) || chan_off) begin
            filter_on_q <= 1'b0;
            shift_q     <= 5'h00;
        end else begin
            filter_on_q <= 1'b1;
            shift_q     <= {1'b0, coef_sel} + 5'h01;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    property p_dc_code_zero;
        (coef_sel == 4'h0) |=> !filter_on_q && (shift_q == 5'h00);
    endproperty
    a_dc_code_zero: assert property (p_dc_code_zero)
        else $error("DC removal active with code zero.");

    property p_dc_shift;
        (coef_sel != 4'h0) && !chan_off |=> filter_on_q && (shift_q == $past(coef_sel) + 5'h01);
    endproperty
    a_dc_shift: assert property (p_dc_shift)
        else $error("DC removal coefficient shift wrong.");

    property p_dc_chan_off;
        chan_off ##1 chan_off |-> !filter_on_q;
    endproperty
    a_dc_chan_off: assert property (p_dc_chan_off)
        else $error("DC removal active although channel disabled it.");

    c_dc_max_shift: cover property (filter_on_q && (shift_q == 5'h10));

endmodule : dc_removal_decode
`default_nettype wire

// ===== channel0_config_calibration_regs.sv
// Channel 0 configuration and calibration register bank behind an AHB-Lite slave.
//
// Added by the designer: the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - Threshold low byte lives in bits 15:8 of threshold register, read/write, resets zero.
// - DC removal code zero switches the filter off; zero is the reset default.
// - Nonzero DC removal code gives coefficient one over two to (code plus one).
// - Ten-bit two's complement phase delay sits in configuration bits 15:6.
// - Configuration bit 2 set disables DC removal for channel 0 only.
// - Configuration bits 1:0 select pins, shorted inputs, positive or negative test.
// - Offset high register holds offset calibration bits 23:8, resetting to zero.
// - Offset low register bits 15:8 hold offset calibration bits 7:0.
// - Low byte of each calibration low register is read-only and reads zero.
// - Gain high register holds gain calibration bits 23:8.
// - Gain high resets to 8000h; all other channel 0 registers reset to zero.
// - Gain low register bits 15:8 hold gain calibration bits 7:0, resetting zero.
// - Configuration at 9h resets 0000h; offset high and low follow at Ah, Bh.
module channel0_config_calibration_regs (
    input  wire logic                       clk,                         // Device clock.
    input  wire logic                       reset,                       // Sync reset, high.
    input  wire logic                       hsel,                        // Slave select.
    input  wire logic [31:0]                haddr,                       // Byte address.
    input  wire logic [1:0]                 htrans,                      // Transfer type.
    input  wire logic                       hwrite,                      // Write when high.
    input  wire logic [2:0]                 hsize,                       // Transfer size.
    input  wire logic                       hready,                      // Bus ready in.
    input  wire logic [31:0]                hwdata,                      // Write data.
    output logic                            hreadyout,                   // Slave ready out.
    output logic                            hresp,                       // Always OKAY.
    output logic [31:0]                     hrdata,                      // Read data.
    output logic [7:0]                      detect_threshold_low_byte,   // Threshold low byte.
    output logic [3:0]                      dc_removal_coefficient_sel,  // Shared DC code.
    output chan0_regs_pkg::chan0_cfg_t      chan0_cfg,                   // Channel 0 config.
    output chan0_regs_pkg::chan0_cal_t      chan0_cal,                   // Calibration words.
    output logic                            chan0_dc_removal_active,     // Filter on for ch 0.
    output logic [4:0]                      chan0_dc_shift               // Coefficient shift.
);
    import chan0_regs_pkg::*;

    // Register storage.
    logic [15:0] thresh_low_q;
    logic [15:0] cfg_q;
    logic [15:0] ocal_hi_q;
    logic [15:0] ocal_lo_q;
    logic [15:0] gcal_hi_q;
    logic [15:0] gcal_lo_q;

    // Bus slave state.
    bus_state_t  bus_state_q;
    logic        hready_q;
    logic [31:0] hrdata_q;
    logic        dp_valid_q;
    logic        dp_write_q;
    logic        dp_mapped_q;
    logic [5:0]  dp_idx_q;

    // Decode of the address phase.
    logic        addr_take;
    logic [5:0]  addr_idx;
    logic        addr_mapped;
    logic        wr_commit;
    logic [15:0] wr_data;
    logic [15:0] rd_value;

    // An address phase is taken only when the bus is ready and a NONSEQ is presented.
    assign addr_take = hsel && hready && (htrans == HTRANS_NONSEQ);
    assign addr_idx  = haddr[ADDR_IDX_MSB:ADDR_IDX_LSB];

    // Only the six word slots of this bank answer; the upper address bits must be clear.
    always_comb begin
        addr_mapped = 1'b0;
        if (haddr[31:8] == 24'h000000) begin
            case (addr_idx)
                IDX_THRESH_LOW, IDX_CFG, IDX_OCAL_HI,
                IDX_OCAL_LO, IDX_GCAL_HI, IDX_GCAL_LO: addr_mapped = 1'b1;
                default:                               addr_mapped = 1'b0;
            endcase
        end
    end

    // Write data are taken at the end of the data phase, which never stalls for a write.
    assign wr_commit = dp_valid_q && dp_write_q && dp_mapped_q && (bus_state_q == BUS_IDLE);
    assign wr_data   = hwdata[15:0];

    // Data phase bookkeeping; hsize is not checked since only whole words are issued.
    always_ff @(posedge clk) begin
        if (reset) begin
            dp_valid_q  <= 1'b0;
            dp_write_q  <= 1'b0;
            dp_mapped_q <= 1'b0;
            dp_idx_q    <= 6'h00;
        end else if (hready_q) begin
            dp_valid_q  <= addr_take;
            dp_write_q  <= addr_take && hwrite;
            dp_mapped_q <= addr_take && addr_mapped;
            dp_idx_q    <= addr_idx;
        end
    end

    // Reads take one wait state so that a write just ahead of them is already stored.
    always_ff @(posedge clk) begin
        if (reset) begin
            bus_state_q <= BUS_IDLE;
            hready_q    <= 1'b1;
        end else begin
            case (bus_state_q)
                BUS_IDLE: begin
                    if (addr_take && !hwrite) begin
                        bus_state_q <= BUS_RDWAIT;
                        hready_q    <= 1'b0;
                    end
                end
                BUS_RDWAIT: begin
                    bus_state_q <= BUS_IDLE;
                    hready_q    <= 1'b1;
                end
                default: begin
                    bus_state_q <= BUS_IDLE;
                    hready_q    <= 1'b1;
                end
            endcase
        end
    end

    // Read multiplexer; reserved bits come out as zero because they are never stored.
    always_comb begin
        rd_value = 16'h0000;
        if (dp_mapped_q) begin
            case (dp_idx_q)
                IDX_THRESH_LOW: rd_value = thresh_low_q;
                IDX_CFG:        rd_value = cfg_q;
                IDX_OCAL_HI:    rd_value = ocal_hi_q;
                IDX_OCAL_LO:    rd_value = ocal_lo_q & WMASK_CAL_LO;
                IDX_GCAL_HI:    rd_value = gcal_hi_q;
                IDX_GCAL_LO:    rd_value = gcal_lo_q & WMASK_CAL_LO;
                default:        rd_value = 16'h0000;
            endcase
        end
    end

    // Read data register; unmapped reads return zero with an OKAY response.
    always_ff @(posedge clk) begin
        if (reset) begin
            hrdata_q <= 32'h00000000;
        end else if (bus_state_q == BUS_RDWAIT) begin
            hrdata_q <= {16'h0000, rd_value};
        end
    end

    // Threshold low byte and shared DC removal code; bits 7:4 are never written.
    always_ff @(posedge clk) begin
        if (reset) begin
            thresh_low_q <= RST_THRESH_LOW;
        end else if (wr_commit && (dp_idx_q == IDX_THRESH_LOW)) begin
            thresh_low_q <= wr_data & WMASK_THRESH_LOW;
        end
    end

    // Channel 0 configuration; the reserved bits 5:3 stay zero whatever is written.
    always_ff @(posedge clk) begin
        if (reset) begin
            cfg_q <= RST_CFG;
        end else if (wr_commit && (dp_idx_q == IDX_CFG)) begin
            cfg_q <= wr_data & WMASK_CFG;
        end
    end

    // Offset calibration words; the low byte of the low register is read-only zero.
    always_ff @(posedge clk) begin
        if (reset) begin
            ocal_hi_q <= RST_OCAL_HI;
            ocal_lo_q <= RST_OCAL_LO;
        end else begin
            if (wr_commit && (dp_idx_q == IDX_OCAL_HI)) begin
                ocal_hi_q <= wr_data & WMASK_CAL_HI;
            end
            if (wr_commit && (dp_idx_q == IDX_OCAL_LO)) begin
                ocal_lo_q <= wr_data & WMASK_CAL_LO;
            end
        end
    end

    // Gain calibration words; a gain of one is the reset value.
    always_ff @(posedge clk) begin
        if (reset) begin
            gcal_hi_q <= RST_GCAL_HI;
            gcal_lo_q <= RST_GCAL_LO;
        end else begin
            if (wr_commit && (dp_idx_q == IDX_GCAL_HI)) begin
                gcal_hi_q <= wr_data & WMASK_CAL_HI;
            end
            if (wr_commit && (dp_idx_q == IDX_GCAL_LO)) begin
                gcal_lo_q <= wr_data & WMASK_CAL_LO;
            end
        end
    end

    // Coefficient decode is registered, so the datapath sees a change one cycle late.
    dc_removal_decode u_dc_decode (
        .clk         (clk),
        .reset       (reset),
        .coef_sel    (thresh_low_q[DCB_SEL_MSB:DCB_SEL_LSB]),
        .chan_off    (cfg_q[DCOFF_BIT]),
        .filter_on_q (chan0_dc_removal_active),
        .shift_q     (chan0_dc_shift)
    );

    // Bus outputs; ready and read data from flip-flops, response tied to OKAY.
    assign hreadyout = hready_q;
    assign hrdata    = hrdata_q;
    assign hresp     = 1'b0;

    // Field outputs, wired straight from the register flip-flops.
    assign detect_threshold_low_byte  = thresh_low_q[THR_BYTE_MSB:THR_BYTE_LSB];
    assign dc_removal_coefficient_sel = thresh_low_q[DCB_SEL_MSB:DCB_SEL_LSB];
    assign chan0_cfg.chan0_phase_delay    = cfg_q[PHASE_MSB:PHASE_LSB];
    assign chan0_cfg.chan0_dc_removal_off = cfg_q[DCOFF_BIT];
    assign chan0_cfg.chan0_input_select   = chan0_input_sel_t'(cfg_q[INSEL_MSB:INSEL_LSB]);
    assign chan0_cal.offset = {ocal_hi_q, ocal_lo_q[CAL_LO_MSB:CAL_LO_LSB]};
    assign chan0_cal.gain   = {gcal_hi_q, gcal_lo_q[CAL_LO_MSB:CAL_LO_LSB]};

    // Checks on the register bank, all in the single clock domain.
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    property p_thresh_write;
        wr_commit && (dp_idx_q == IDX_THRESH_LOW)
            |=> (detect_threshold_low_byte == $past(hwdata[15:8]))
                && (dc_removal_coefficient_sel == $past(hwdata[3:0]));
    endproperty
    a_thresh_write: assert property (p_thresh_write)
        else $error("Threshold low byte not stored from the write.");

    property p_phase_write;
        wr_commit && (dp_idx_q == IDX_CFG)
            |=> (chan0_cfg.chan0_phase_delay == $past(hwdata[15:6]))
                && (chan0_cfg.chan0_dc_removal_off == $past(hwdata[2]));
    endproperty
    a_phase_write: assert property (p_phase_write)
        else $error("Phase delay or channel filter disable not stored.");

    property p_insel_write;
        wr_commit && (dp_idx_q == IDX_CFG)
            |=> chan0_cfg.chan0_input_select == chan0_input_sel_t'($past(hwdata[1:0]));
    endproperty
    a_insel_write: assert property (p_insel_write)
        else $error("Input selection not stored from the write.");

    property p_offset_write;
        wr_commit && (dp_idx_q == IDX_OCAL_HI)
            |=> chan0_cal.offset[23:8] == $past(hwdata[15:0]);
    endproperty
    a_offset_write: assert property (p_offset_write)
        else $error("Offset calibration upper bits not stored.");

    property p_offset_low_write;
        wr_commit && (dp_idx_q == IDX_OCAL_LO)
            |=> (chan0_cal.offset[7:0] == $past(hwdata[15:8])) && $stable(chan0_cal.offset[23:8]);
    endproperty
    a_offset_low_write: assert property (p_offset_low_write)
        else $error("Offset calibration lower bits not stored.");

    property p_cal_low_reads_zero;
        (bus_state_q == BUS_RDWAIT) && ((dp_idx_q == IDX_OCAL_LO) || (dp_idx_q == IDX_GCAL_LO))
            |=> hreadyout && (hrdata[7:0] == 8'h00);
    endproperty
    a_cal_low_reads_zero: assert property (p_cal_low_reads_zero)
        else $error("Calibration low register returned nonzero low byte.");

    property p_gain_write;
        wr_commit && (dp_idx_q == IDX_GCAL_HI)
            |=> chan0_cal.gain[23:8] == $past(hwdata[15:0]);
    endproperty
    a_gain_write: assert property (p_gain_write)
        else $error("Gain calibration upper bits not stored.");

    property p_reset_values;
        $past(reset) |-> (chan0_cal.gain == 24'h800000) && (chan0_cal.offset == 24'h000000)
            && (cfg_q == RST_CFG) && (thresh_low_q == RST_THRESH_LOW);
    endproperty
    a_reset_values: assert property (p_reset_values)
        else $error("Register bank left reset with wrong values.");

    property p_gain_low_write;
        wr_commit && (dp_idx_q == IDX_GCAL_LO)
            |=> (chan0_cal.gain[7:0] == $past(hwdata[15:8])) && $stable(chan0_cal.gain[23:8]);
    endproperty
    a_gain_low_write: assert property (p_gain_low_write)
        else $error("Gain calibration lower bits not stored.");

    property p_cfg_readback;
        addr_take && !hwrite && addr_mapped && (addr_idx == IDX_CFG) && hready_q
            |=> !hreadyout ##1 (hreadyout && (hrdata == {16'h0000, $past(cfg_q)}));
    endproperty
    a_cfg_readback: assert property (p_cfg_readback)
        else $error("Configuration read at index 9 returned wrong data or timing.");

    property p_reserved_zero;
        wr_commit |=> (cfg_q[5:3] == 3'h0) && (thresh_low_q[7:4] == 4'h0)
            && (ocal_lo_q[7:0] == 8'h00) && (gcal_lo_q[7:0] == 8'h00);
    endproperty
    a_reserved_zero: assert property (p_reserved_zero)
        else $error("Reserved bits took written data.");

    property p_okay_only;
        hresp == 1'b0;
    endproperty
    a_okay_only: assert property (p_okay_only)
        else $error("Slave answered with a response other than OKAY.");

    // Bus timing as the master sees it; one read wait state buys read-after-write coherence.
    property p_read_wait;
        addr_take && !hwrite |=> !hreadyout ##1 hreadyout;
    endproperty
    a_read_wait: assert property (p_read_wait)
        else $error("Read did not take exactly one wait state.");

    property p_write_no_wait;
        addr_take && hwrite |=> hreadyout;
    endproperty
    a_write_no_wait: assert property (p_write_no_wait)
        else $error("Write data phase stalled.");

    // Unmapped reads answer zero with the same timing, so a probe of the map is harmless.
    property p_unmapped_read_zero;
        addr_take && !hwrite && !addr_mapped |=> ##1 (hrdata == 32'h00000000);
    endproperty
    a_unmapped_read_zero: assert property (p_unmapped_read_zero)
        else $error("Unmapped read returned nonzero data.");

    // The decoder output must follow the stored code and channel disable one cycle later.
    property p_dc_follows_regs;
        1'b1 |=> chan0_dc_removal_active
            == (($past(dc_removal_coefficient_sel) != 4'h0)
                && !$past(chan0_cfg.chan0_dc_removal_off));
    endproperty
    a_dc_follows_regs: assert property (p_dc_follows_regs)
        else $error("DC removal enable does not follow the registers.");

    // Reserved bits are never stored, whatever the bus history.
    property p_reserved_always_zero;
        (cfg_q[5:3] == 3'h0) && (thresh_low_q[7:4] == 4'h0)
            && (ocal_lo_q[7:0] == 8'h00) && (gcal_lo_q[7:0] == 8'h00);
    endproperty
    a_reserved_always_zero: assert property (p_reserved_always_zero)
        else $error("Reserved bits hold a nonzero value.");

    // Main scenarios worth seeing.
    c_cfg_read: cover property (addr_take && !hwrite && (addr_idx == IDX_CFG) ##2 hreadyout);
    c_gain_write: cover property (wr_commit && (dp_idx_q == IDX_GCAL_HI));
    c_write_then_read: cover property (addr_take && hwrite ##1 addr_take && !hwrite);
    c_dc_active: cover property (chan0_dc_removal_active && !chan0_cfg.chan0_dc_removal_off);

endmodule : channel0_config_calibration_regs
`default_nettype wire

// ===== testbench.sv
// Self-checking testbench for the channel 0 configuration and calibration register bank.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import chan0_regs_pkg::*;

    logic        clk;
    logic        reset;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [31:0] hwdata;
    logic        hreadyout;
    logic        hresp;
    logic [31:0] hrdata;
    logic [7:0]  thr_byte;
    logic [3:0]  dc_sel;
    chan0_cfg_t  cfg;
    chan0_cal_t  cal;
    logic        dc_active;
    logic [4:0]  dc_shift;
    int          bad_count;
    int          compares;
    logic [31:0] rd;

    // Ordinary cases: register index, written word, word expected on read back.
    logic [5:0]  row_idx [7] = '{6'h08, 6'h09, 6'h0A, 6'h0B, 6'h0C, 6'h0D, 6'h3F};
    logic [31:0] row_wr  [7] = '{32'hFFFFFFFF, 32'hFFFFFFFF, 32'h00001234, 32'h0000FFFF,
                                 32'h0000ABCD, 32'h00005AA5, 32'h0000FFFF};
    logic [31:0] row_rd  [7] = '{32'h0000FF0F, 32'h0000FFC7, 32'h00001234, 32'h0000FF00,
                                 32'h0000ABCD, 32'h00005A00, 32'h00000000};
    logic [15:0] rst_exp [6] = '{RST_THRESH_LOW, RST_CFG, RST_OCAL_HI, RST_OCAL_LO,
                                 RST_GCAL_HI, RST_GCAL_LO};
    logic [3:0]  dc_codes [4] = '{4'h0, 4'h1, 4'hF, 4'h4};

    channel0_config_calibration_regs u_channel0_config_calibration_regs (
        .clk                        (clk),
        .reset                      (reset),
        .hsel                       (hsel),
        .haddr                      (haddr),
        .htrans                     (htrans),
        .hwrite                     (hwrite),
        .hsize                      (3'h2),
        .hready                     (hreadyout),
        .hwdata                     (hwdata),
        .hreadyout                  (hreadyout),
        .hresp                      (hresp),
        .hrdata                     (hrdata),
        .detect_threshold_low_byte  (thr_byte),
        .dc_removal_coefficient_sel (dc_sel),
        .chan0_cfg                  (cfg),
        .chan0_cal                  (cal),
        .chan0_dc_removal_active    (dc_active),
        .chan0_dc_shift             (dc_shift)
    );

    // Free-running 250 MHz device clock.
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    task complete_run;
        $display("Counts: %0d comparisons, %0d mismatches", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : complete_run

    task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    // Ready is looked at on the falling edge, where it is settled and equals what the
    // next rising edge samples; the task then returns just after that rising edge.
    task wait_ready(output logic [31:0] d);
        int n;
        n = 0;
        @(negedge clk);
        while (hreadyout !== 1'b1 && n < 50) begin
            n++;
            @(negedge clk);
        end
        if (n >= 50) begin
            bad_count++;
            $display("MISMATCH hreadyout expected 1 seen stuck");
        end
        d = hrdata;
        @(posedge clk);
    endtask : wait_ready

    task bus_write(input logic [5:0] idx, input logic [31:0] data);
        logic [31:0] dummy;
        haddr  <= {24'h0, idx, 2'b00};
        hwrite <= 1'b1;
        htrans <= HTRANS_NONSEQ;
        hsel   <= 1'b1;
        wait_ready(dummy);
        htrans <= HTRANS_IDLE;
        hwdata <= data;
        wait_ready(dummy);
    endtask : bus_write

    task bus_read(input logic [5:0] idx, output logic [31:0] d);
        logic [31:0] dummy;
        haddr  <= {24'h0, idx, 2'b00};
        hwrite <= 1'b0;
        htrans <= HTRANS_NONSEQ;
        hsel   <= 1'b1;
        wait_ready(dummy);
        htrans <= HTRANS_IDLE;
        wait_ready(d);
        chk("hresp", 32'h0, {31'h0, hresp});
    endtask : bus_read

    // Main sequence: reset values, table of writes and reads, field outputs, second reset.
    initial begin
        bad_count = 0;
        compares  = 0;
        reset     = 1'b1;
        hsel      = 1'b0;
        haddr     = 32'h0;
        htrans    = HTRANS_IDLE;
        hwrite    = 1'b0;
        hwdata    = 32'h0;
        repeat (6) @(posedge clk);
        reset <= 1'b0;
        for (int i = 0; i < 6; i++) begin
            bus_read(6'h08 + 6'(i), rd);
            chk("reset value", {16'h0, rst_exp[i]}, rd);
        end
        chk("reset offset", 32'h0, {8'h0, cal.offset});
        chk("reset gain", 32'h00800000, {8'h0, cal.gain});
        $display("Test reset values done");
        // Each write is read back at once, with the read address phase in the cycle right after the write data phase ends.
        for (int i = 0; i < 7; i++) begin
            bus_write(row_idx[i], row_wr[i]);
            bus_read(row_idx[i], rd);
            chk("read back", row_rd[i], rd);
        end
        $display("Test register table done");
        chk("threshold byte", 32'hFF, {24'h0, thr_byte});
        chk("offset", {8'h0, 24'h1234FF}, {8'h0, cal.offset});
        chk("gain", {8'h0, 24'hABCD5A}, {8'h0, cal.gain});
        $display("Test field outputs done");
        // Codes off, smallest, largest, and a nonzero code overridden by the channel disable.
        for (int i = 0; i < 4; i++) begin
            bus_write(6'h08, {28'h0, dc_codes[i]});
            bus_write(6'h09, {16'h0, 10'h200 | 10'(i), 3'b000, i == 3, 2'(i)});
            repeat (3) @(posedge clk);
            @(negedge clk);
            chk("phase", {22'h0, 10'h200 | 10'(i)}, {22'h0, cfg.chan0_phase_delay});
            chk("input select", i, {30'h0, cfg.chan0_input_select});
            chk("dc off", (i == 3), {31'h0, cfg.chan0_dc_removal_off});
            chk("dc code", {28'h0, dc_codes[i]}, {28'h0, dc_sel});
            chk("dc active", (dc_codes[i] != 0 && i != 3), {31'h0, dc_active});
            chk("dc shift", (dc_codes[i] != 0 && i != 3) ? dc_codes[i] + 1 : 0,
                {27'h0, dc_shift});
            @(posedge clk);
        end
        $display("Test dc removal and input select done");
        reset <= 1'b1;
        repeat (6) @(posedge clk);
        reset <= 1'b0;
        bus_read(6'h0C, rd);
        chk("gain high after reset", 32'h8000, rd);
        bus_read(6'h09, rd);
        chk("config after reset", 32'h0, rd);
        bus_read(6'h0B, rd);
        chk("offset low after reset", 32'h0, rd);
        $display("Test second reset done");
        complete_run();
    end

    // Watchdog: the whole sequence needs well under 1000 cycles.
    initial begin
        #40000;
        bad_count++;
        $display("MISMATCH watchdog expected finish seen hang");
        complete_run();
    end

endmodule : testbench
`default_nettype wire
